// ==== rtl/cupf_pkg.sv ====
// Purpose: Shared constants and carrier types of the card UART parity and FIFO setup block.
// Assumes: One 20 MHz clock; times are counted in half ETU ticks from the baud logic.
// Notes: Offsets are byte addresses on a 32-bit AHB-Lite bus.
package cupf_pkg;
   // Register byte offsets
   localparam logic [7:0] CFG_OFFSET = 8'h0C; // Parity and FIFO configuration, write only
   localparam logic [7:0] STAT_OFFSET = 8'h10; // Status view
   localparam logic [7:0] CTRL_OFFSET = 8'h14; // Protocol and direction control
   // Configuration field positions
   localparam int ERR_CNT_LSB = 4; // Error count field, bits 6 to 4
   localparam int FIFO_DEPTH_LSB = 0; // FIFO depth field, bits 2 to 0
   localparam int FIELD_W = 3;
   localparam logic [7:0] CFG_RESET = 8'h00; // Reset value of the configuration
   localparam logic [7:0] CFG_MASK = 8'h77; // Meaningful configuration bits
   // Control field positions
   localparam int CTRL_T1_BIT = 0; // 1 selects protocol T = 1
   localparam int CTRL_TX_BIT = 1; // 1 selects transmission mode
   localparam logic [1:0] CTRL_RESET = 2'h0;
   // Status field positions
   localparam int STAT_PE_BIT = 0; // Parity error flag
   localparam int STAT_CNT_LSB = 4; // Current error count
   // Character timing in half ETU steps from the character start
   localparam int HALF_PER_ETU = 2;
   localparam real RX_FLAG_ETU = 10.5; // Flag point in reception
   localparam real TX_FLAG_ETU = 11.5; // Flag point in transmission
   localparam real MANUAL_ETU = 13.5; // Manual rewrite start point
   localparam real RETX_ETU = 15.0; // Automatic repeat start point
   localparam logic [4:0] RX_FLAG_HALF = 5'(int'(RX_FLAG_ETU * HALF_PER_ETU));
   localparam logic [4:0] TX_FLAG_HALF = 5'(int'(TX_FLAG_ETU * HALF_PER_ETU));
   localparam logic [4:0] MANUAL_HALF = 5'(int'(MANUAL_ETU * HALF_PER_ETU));
   localparam logic [4:0] RETX_HALF = 5'(int'(RETX_ETU * HALF_PER_ETU));
   // AHB-Lite codes
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [1:0] HTRANS_SEQ = 2'h3;
   localparam logic HRESP_OKAY = 1'b0;

   // Events from the character engine, same clock
   typedef struct packed {
      logic char_start; // Pulse at a start bit
      logic half_etu_tick; // Pulse every half ETU
      logic parity_bad; // Level, valid at the flag point of a received character
      logic card_nak; // Level, valid at the flag point of a sent character
   } cupf_link_t;

   // Actions toward the character engine and FIFO
   typedef struct packed {
      logic fifo_store; // Pulse: write received character into FIFO
      logic fifo_drop; // Pulse: discard received character
      logic retransmit; // Pulse: start automatic repeat now
      logic rewrite_ok; // Pulse: manual rewrite may start now
   } cupf_act_t;
endpackage : cupf_pkg

// ==== rtl/cupf_top.sv ====
// Purpose: Parity error counting, retry control and FIFO depth setup of a card UART.
// Assumes: AHB-Lite master, single word transfers; events arrive on the same clock.
// Notes: Zero wait state slave; reads return data in the data phase.
// Contract
// - Reset clears configuration: threshold one, depth one
// - Bits 6..4 set allowed repetitions before flag
// - Threshold equals error count field plus one
// - T0: good character clears the error counter
// - T0: flag holds until status register read
// - T0: NAKed character repeated automatically at 15 ETU
// - Field zero: no repeat, manual rewrite 13.5
// - T1: counter idle, first bad character flags
// - Bits 2..0 set FIFO depth one to eight
// - Flag at 10.5 ETU receive, 11.5 transmit
// - T0 drops bad characters, T1 stores them
`timescale 1ns/1ps
`default_nettype none
module cupf_top (
   // Clock, reset, enable
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic clk_en,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [7:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // Character engine side
   input wire cupf_pkg::cupf_link_t link,
   output cupf_pkg::cupf_act_t act,
   output logic [2:0] fifo_depth_code,
   output logic parity_error_flag,
   output logic main_interrupt_n
);
   // Address phase capture
   logic wr_pend_q; // Write data phase pending
   logic [7:0] wr_addr_q; // Address of pending write
   logic [31:0] hrdata_q; // Read data register
   // Registers
   logic [7:0] cfg_q; // Parity and FIFO configuration
   logic [1:0] ctrl_q; // Protocol and direction
   logic pe_q; // Parity error flag
   logic [2:0] err_cnt_q; // Consecutive error count
   // Character timer
   logic timer_on_q; // Timer running for a character
   logic [4:0] half_q; // Half ETU count since start
   logic retx_pend_q; // Automatic repeat armed
   logic manual_pend_q; // Manual rewrite point armed
   cupf_pkg::cupf_act_t act_q; // Registered actions
   logic irq_n_q; // Interrupt pin register
   // Decode helpers
   logic addr_ok;
   logic rd_stat;
   logic t1_mode;
   logic tx_mode;
   logic [2:0] err_field;
   logic flag_point;
   logic bad_now;
   logic reach;
   logic set_pe;

   // True when the address phase is a valid transfer
   function automatic logic xfer(input logic [1:0] tr, input logic sel, input logic rdy);
      xfer = sel && rdy && (tr == cupf_pkg::HTRANS_NONSEQ || tr == cupf_pkg::HTRANS_SEQ);
   endfunction : xfer

   assign addr_ok = xfer(htrans, hsel, hready);
   assign rd_stat = addr_ok && !hwrite && (haddr == cupf_pkg::STAT_OFFSET);
   assign t1_mode = ctrl_q[cupf_pkg::CTRL_T1_BIT];
   assign tx_mode = ctrl_q[cupf_pkg::CTRL_TX_BIT];
   assign err_field = cfg_q[cupf_pkg::ERR_CNT_LSB +: cupf_pkg::FIELD_W];
   // Decision point depends on direction
   assign flag_point = timer_on_q && link.half_etu_tick &&
      (half_q + 5'h01 == (tx_mode ? cupf_pkg::TX_FLAG_HALF : cupf_pkg::RX_FLAG_HALF));
   assign bad_now = tx_mode ? link.card_nak : link.parity_bad;
   // Count after this error reaches field plus one
   assign reach = (err_cnt_q == err_field);
   assign set_pe = flag_point && bad_now && (t1_mode || reach);

   // Bus address phase capture for writes
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_q <= 1'b0;
         wr_addr_q <= 8'h00;
      end else if (clk_en) begin
         if (hready) begin
            wr_pend_q <= addr_ok && hwrite;
            wr_addr_q <= haddr;
         end
      end
   end

   // Read data, loaded at the address phase edge
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata_q <= 32'h0000_0000;
      end else if (clk_en) begin
         if (addr_ok && !hwrite) begin
            unique case (haddr)
               cupf_pkg::STAT_OFFSET: begin
                  hrdata_q <= {25'h0000000, err_cnt_q, 3'h0, pe_q};
               end
               cupf_pkg::CTRL_OFFSET: begin
                  hrdata_q <= {30'h00000000, ctrl_q};
               end
               default: begin
                  // Configuration is write only; unmapped reads zero
                  hrdata_q <= 32'h0000_0000;
               end
            endcase
         end
      end
   end

   // Configuration register write
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cfg_q <= cupf_pkg::CFG_RESET;
      end else if (clk_en) begin
         if (wr_pend_q && wr_addr_q == cupf_pkg::CFG_OFFSET) begin
            cfg_q <= hwdata[7:0] & cupf_pkg::CFG_MASK;
         end
      end
   end

   // Control register write
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_q <= cupf_pkg::CTRL_RESET;
      end else if (clk_en) begin
         if (wr_pend_q && wr_addr_q == cupf_pkg::CTRL_OFFSET) begin
            ctrl_q <= hwdata[1:0];
         end
      end
   end

   // Half ETU timer from each character start
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         timer_on_q <= 1'b0;
         half_q <= 5'h00;
      end else if (clk_en) begin
         if (link.char_start) begin
            timer_on_q <= 1'b1;
            half_q <= 5'h00;
         end else if (timer_on_q && link.half_etu_tick) begin
            half_q <= half_q + 5'h01;
            // Stop after the latest point of interest
            if (half_q + 5'h01 == cupf_pkg::RETX_HALF) begin
               timer_on_q <= 1'b0;
            end
         end
      end
   end

   // Error counter
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         err_cnt_q <= 3'h0;
      end else if (clk_en) begin
         if (flag_point) begin
            if (t1_mode) begin
               err_cnt_q <= 3'h0;
            end else if (!bad_now) begin
               err_cnt_q <= 3'h0;
            end else if (reach) begin
               err_cnt_q <= 3'h0;
            end else begin
               err_cnt_q <= err_cnt_q + 3'h1;
            end
         end
      end
   end

   // Parity error flag; a new set wins over the read clear
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pe_q <= 1'b0;
      end else if (clk_en) begin
         if (set_pe) begin
            pe_q <= 1'b1;
         end else if (rd_stat) begin
            pe_q <= 1'b0;
         end
      end
   end

   // Retry arming in transmission
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         retx_pend_q <= 1'b0;
         manual_pend_q <= 1'b0;
      end else if (clk_en) begin
         if (link.char_start) begin
            retx_pend_q <= 1'b0;
            manual_pend_q <= 1'b0;
         end else if (flag_point && tx_mode && bad_now) begin
            // Repeat only in T0 while below the threshold
            retx_pend_q <= !t1_mode && !reach;
            // Field zero leaves the repeat to software
            manual_pend_q <= (err_field == 3'h0);
         end else if (timer_on_q && link.half_etu_tick) begin
            if (half_q + 5'h01 == cupf_pkg::RETX_HALF) begin
               retx_pend_q <= 1'b0;
            end
            if (half_q + 5'h01 == cupf_pkg::MANUAL_HALF) begin
               manual_pend_q <= 1'b0;
            end
         end
      end
   end

   // Action pulses toward the engine and FIFO
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         act_q <= '0;
      end else if (clk_en) begin
         act_q <= '0;
         if (flag_point && !tx_mode) begin
            // Bad characters are kept only in T1
            act_q.fifo_store <= !bad_now || t1_mode;
            act_q.fifo_drop <= bad_now && !t1_mode;
         end
         if (timer_on_q && link.half_etu_tick) begin
            act_q.retransmit <= retx_pend_q &&
               (half_q + 5'h01 == cupf_pkg::RETX_HALF);
            act_q.rewrite_ok <= manual_pend_q &&
               (half_q + 5'h01 == cupf_pkg::MANUAL_HALF);
         end
      end
   end

   // Interrupt pin follows the flag, active low
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_n_q <= 1'b1;
      end else if (clk_en) begin
         irq_n_q <= !(set_pe || (pe_q && !rd_stat));
      end
   end

   // Bus handshake outputs, always ready and OKAY
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b1;
         hresp <= cupf_pkg::HRESP_OKAY;
      end else if (clk_en) begin
         hreadyout <= 1'b1;
         hresp <= cupf_pkg::HRESP_OKAY;
      end
   end

   assign hrdata = hrdata_q;
   assign act = act_q;
   assign fifo_depth_code = cfg_q[cupf_pkg::FIFO_DEPTH_LSB +: cupf_pkg::FIELD_W];
   assign parity_error_flag = pe_q;
   assign main_interrupt_n = irq_n_q;
endmodule : cupf_top
`default_nettype wire

// ==== verification/cupf_card_model.sv ====
// Purpose: Character engine stand-in that makes start pulses, ticks and error levels.
// Assumes: One start per go; gap sets cycles between half ETU ticks.
// Notes: Error lines toggle between frames so stale levels never look valid.
`timescale 1ns/1ps
`default_nettype none
module cupf_card_model (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // Bench commands
   input wire logic go,
   input wire logic bad,
   input wire logic [1:0] gap,
   // Engine side
   output cupf_pkg::cupf_link_t link,
   output logic busy
);
   logic [5:0] tick_q; // Half ETU ticks sent
   logic [1:0] wait_q; // Cycles to next tick
   // One frame of 32 half ETU ticks
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         link <= '0;
         busy <= 1'b0;
         tick_q <= 6'h00;
         wait_q <= 2'h0;
      end else begin
         link.char_start <= go & ~busy;
         link.half_etu_tick <= busy && wait_q == 2'h0;
         link.parity_bad <= busy ? bad : ~link.parity_bad;
         link.card_nak <= busy ? bad : ~link.card_nak;
         if (go && !busy) begin
            busy <= 1'b1;
            tick_q <= 6'h00;
            wait_q <= gap;
         end else if (busy && wait_q != 2'h0) begin
            wait_q <= wait_q - 2'h1;
         end else if (busy) begin
            wait_q <= gap;
            tick_q <= tick_q + 6'h01;
            busy <= tick_q != 6'h1F;
         end
      end
   end
endmodule : cupf_card_model
`default_nettype wire

// ==== verification/cupf_top_monitor.sv ====
// Purpose: Timing and register checks on the parity and FIFO setup block.
// Assumes: Watches top ports only; half ETU position is rebuilt here.
// Notes: Attached by bind below.
`timescale 1ns/1ps
`default_nettype none
module cupf_top_monitor (
   // Clock, reset, bus
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic clk_en,
   input wire logic hsel,
   input wire logic [7:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   // Engine side
   input wire cupf_pkg::cupf_link_t link,
   input wire cupf_pkg::cupf_act_t act,
   input wire logic [2:0] fifo_depth_code,
   input wire logic parity_error_flag,
   input wire logic main_interrupt_n
);
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   logic [4:0] cnt_q; // Half ETU position in the character
   logic wr_cfg_q; // Data phase of a configuration write
   wire acc = hsel && hready && htrans[1] && clk_en;
   wire rd_st = acc && !hwrite && haddr == cupf_pkg::STAT_OFFSET;
   wire hit20 = link.half_etu_tick && cnt_q == 5'h14;
   wire hit22 = link.half_etu_tick && cnt_q == 5'h16;
   wire hit26 = link.half_etu_tick && cnt_q == 5'h1A;
   wire hit29 = link.half_etu_tick && cnt_q == 5'h1D;
   // Position counter and write tracker
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt_q <= 5'h00;
         wr_cfg_q <= 1'b0;
      end else begin
         cnt_q <= link.char_start ? 5'h00 : cnt_q + 5'(link.half_etu_tick);
         wr_cfg_q <= acc && hwrite && haddr == cupf_pkg::CFG_OFFSET;
      end
   end
   property p_irq; main_interrupt_n == !parity_error_flag; endproperty
   property p_flag_at; $rose(parity_error_flag) |-> $past(hit20) || $past(hit22); endproperty
   property p_depth; wr_cfg_q |=> fifo_depth_code == $past(hwdata[2:0]); endproperty
   property p_store; act.fifo_store || act.fifo_drop |-> $past(hit20); endproperty
   property p_retx; act.retransmit |-> $past(hit29) || $past(hit29, 2); endproperty
   property p_rew; act.rewrite_ok |-> $past(hit26) || $past(hit26, 2); endproperty
   property p_reset; $rose(hresetn) |-> fifo_depth_code == 3'h0 && !parity_error_flag; endproperty
   property p_hold; parity_error_flag && !rd_st |=> parity_error_flag; endproperty
   a_irq: assert property (p_irq)
      else $error("interrupt line disagrees with flag");
   a_flag_at: assert property (p_flag_at)
      else $error("flag rose off the decision point");
   a_depth: assert property (p_depth)
      else $error("depth code not taken from write");
   a_store: assert property (p_store)
      else $error("store or drop off the decision point");
   a_retx: assert property (p_retx)
      else $error("repeat pulse off 15 ETU");
   a_rew: assert property (p_rew)
      else $error("rewrite pulse off 13.5 ETU");
   a_reset: assert property (p_reset)
      else $error("setup not cleared by reset");
   a_hold: assert property (p_hold)
      else $error("flag dropped without status read");
   c_flag: cover property ($rose(parity_error_flag));
   c_retx: cover property (act.retransmit);
   c_rew: cover property (act.rewrite_ok);
endmodule : cupf_top_monitor
bind cupf_top cupf_top_monitor u_cupf_top_monitor (.*);
`default_nettype wire

// ==== verification/test_cupf_top.sv ====
// Purpose: Random and corner checks of error counting, retry and FIFO depth.
// Assumes: Zero wait slave; card model makes characters.
// Notes: Pulse counters cnt: 3 store, 2 drop, 1 repeat, 0 rewrite.
`timescale 1ns/1ps
`default_nettype none
module test_cupf_top;
   logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, go = 0, bad = 0, hreadyout, hresp;
   logic flag, irq_n, busy;
   logic [7:0] haddr = 8'h00;
   logic [1:0] htrans = 2'h0, gap = 2'h0;
   logic [31:0] hwdata = 32'h0, hrdata, r;
   logic [2:0] depth;
   cupf_pkg::cupf_link_t link;
   cupf_pkg::cupf_act_t act;
   int n_fail = 0, n_compared = 0, seed = 28300, f, dp, cnt[4];
   initial forever #25 hclk = ~hclk;
   cupf_top u_cupf_top (.hclk(hclk), .hresetn(hresetn), .clk_en(1'b1), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .link(link), .act(act), .fifo_depth_code(depth), .parity_error_flag(flag),
      .main_interrupt_n(irq_n));
   cupf_card_model u_cupf_card_model (.hclk(hclk), .hresetn(hresetn), .go(go), .bad(bad),
      .gap(gap), .link(link), .busy(busy));
   // Count action pulses
   always @(posedge hclk) for (int i = 0; i < 4; i++) cnt[i] += int'(act[i]);
   function automatic logic [31:0] cfg(input int e, input int d);
      return 32'h88 | 32'(e << 4) | 32'(d);
   endfunction : cfg
   task give_verdict;
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : give_verdict
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_fail++;
         $display("Error %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task wait_rdy;
      int k;
      k = 0;
      @(posedge hclk);
      while (hreadyout !== 1'b1) begin
         if (++k > 20) begin n_fail++; give_verdict; end
         @(posedge hclk);
      end
   endtask : wait_rdy
   task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= cupf_pkg::HTRANS_NONSEQ;
      haddr <= a;
      hwrite <= w;
      wait_rdy;
      htrans <= 2'h0;
      hwdata <= d;
      wait_rdy;
      r = hrdata;
      chk(hresp, cupf_pkg::HRESP_OKAY);
   endtask : bus
   task char(input logic b);
      int k;
      k = 0;
      go <= 1'b1;
      bad <= b;
      gap <= 2'($random(seed));
      @(posedge hclk);
      go <= 1'b0;
      do begin
         @(posedge hclk);
         if (++k > 400) begin n_fail++; give_verdict; end
      end while (busy !== 1'b0);
      repeat (3) @(posedge hclk);
   endtask : char
   initial begin
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      chk({depth, flag, irq_n}, 32'h1);
      bus(0, cupf_pkg::CFG_OFFSET, 0);
      chk(r, 0);
      bus(0, 8'h40, 0);
      chk(r, 0);
      repeat (4) begin
         f = $random(seed) & 7;
         dp = $random(seed) & 7;
         bus(1, cupf_pkg::CTRL_OFFSET, 0);
         bus(1, cupf_pkg::CFG_OFFSET, cfg(f, dp));
         @(posedge hclk);
         chk(depth, dp);
         cnt = '{default: 0};
         repeat (f) char(1);
         chk({flag, irq_n}, 32'h1);
         chk(cnt[2], f);
         char(0);
         chk(cnt[3], 1);
         bus(0, cupf_pkg::STAT_OFFSET, 0);
         chk(r & 32'h71, 0);
         repeat (f + 1) char(1);
         chk({flag, irq_n}, 32'h2);
         char(0);
         chk(flag, 1);
         bus(0, cupf_pkg::STAT_OFFSET, 0);
         chk(r & 32'h71, 1);
         chk(flag, 0);
      end
      bus(1, cupf_pkg::CTRL_OFFSET, 1);
      bus(1, cupf_pkg::CFG_OFFSET, cfg(7, 0));
      cnt = '{default: 0};
      char(1);
      chk({flag, 1'(cnt[3]), 1'(cnt[2])}, 32'h6);
      bus(0, cupf_pkg::STAT_OFFSET, 0);
      f = 1 + $unsigned($random(seed)) % 7;
      bus(1, cupf_pkg::CTRL_OFFSET, 2);
      bus(1, cupf_pkg::CFG_OFFSET, cfg(f, 0));
      cnt = '{default: 0};
      repeat (f) char(1);
      chk({flag, 3'(cnt[1])}, 32'(f));
      char(1);
      chk({flag, 3'(cnt[1])}, 32'(8 + f));
      bus(0, cupf_pkg::STAT_OFFSET, 0);
      bus(1, cupf_pkg::CFG_OFFSET, cfg(0, 0));
      cnt = '{default: 0};
      char(1);
      chk({flag, 1'(cnt[1]), 1'(cnt[0])}, 32'h5);
      char(0);
      give_verdict;
   end
endmodule : test_cupf_top
`default_nettype wire
